// >>> lpf_pkg.sv
// shared constants of the led / general-purpose pin function select block
// assumes a 32-bit apb register slave clocked by ref_clk at 40 mhz
package lpf_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] LPF_CFG_OFF  = 12'h024; // led_pin_function_config
    localparam logic [11:0] LPF_WAKE_OFF = 12'h0A0; // pin wake enable and polarity
    localparam logic [11:0] LPF_LEDC_OFF = 12'h0A4; // duplex led software control

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LPF_ROLE_BIT    = 31; // led_role_select
    localparam int LPF_P10_LSB     = 24; // pin 10 function select, 2 bits
    localparam int LPF_P9_LSB      = 20; // pin9_function_select, 2 bits
    localparam int LPF_BUF_LSB     = 9;  // push-pull select, pin 9 then pin 10
    localparam int LPF_DIR_LSB     = 5;  // output direction, pin 9 then pin 10
    localparam int LPF_DAT_LSB     = 1;  // pin data, pin 9 then pin 10
    localparam int LPF_WK_EN_LSB   = 0;  // wake enable, pin 9 then pin 10
    localparam int LPF_WK_POL_LSB  = 8;  // wake polarity, 1 = rising
    localparam int LPF_DPX_EN_BIT  = 0;  // software owns the duplex led while role is 0
    localparam int LPF_DPX_LIT_BIT = 1;  // duplex led lit when owned

    // ------------------------------------------------------------
    // reset values and function codes
    // ------------------------------------------------------------
    localparam logic       LPF_ROLE_RST = 1'h0;
    localparam logic [1:0] LPF_FN_RST   = 2'h0;
    localparam logic [1:0] LPF_FN_GPIO  = 2'h0;
    localparam logic [1:0] LPF_FN_LED   = 2'h1;
    localparam logic [1:0] LPF_FN_MIRA  = 2'h2; // pin 9: rxd1, pin 10: rxd0
    localparam logic [1:0] LPF_FN_MIRB  = 2'h3; // pin 9: phy reset, pin 10: rxd3
    localparam logic       LPF_LED_OFF  = 1'h1; // leds are active low

    // apb answer sequencer
    typedef enum logic [1:0] {
        LPF_IDLE = 2'b01,
        LPF_ACK  = 2'b10
    } lpf_apb_state_t;

    // led level for an active-low indicator
    function automatic logic lpf_led_n(input logic lit);
        return ~lit;
    endfunction

endpackage

// >>> lpf_reg_if.sv
// register access carrier between the apb slave and the register file
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lpf_reg_if;
    logic        wr;    // one-cycle write strobe, decoded address hit
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;   // address maps to a register

    modport slave (output wr, output addr, output wdata, input rdata, input hit);
    modport regs  (input wr, input addr, input wdata, output rdata, output hit);
endinterface

// >>> lpf_pin_mux.sv
// output mux of one shared general-purpose pin
// assumes the caller registers the outputs; purely combinational
`timescale 1ns/1ps
module lpf_pin_mux
    import lpf_pkg::*;
(
    input  wire logic [1:0] fn,
    input  wire logic       dir,
    input  wire logic       push_pull,
    input  wire logic       dat,
    input  wire logic       led_n,
    input  wire logic       mir_a,
    input  wire logic       mir_b,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            gp_input
);
    // ------------------------------------------------------------
    // function select
    // ------------------------------------------------------------
    // open-drain only pulls low, so a high level releases the pin
    always_comb begin
        gp_input = 1'b0;
        case (fn)
            LPF_FN_GPIO: begin
                gp_input = ~dir;
                pin_out  = push_pull ? dat : 1'b0;
                pin_oe   = dir & (push_pull | ~dat);
            end
            LPF_FN_LED: begin
                pin_out = led_n;
                pin_oe  = 1'b1;
            end
            LPF_FN_MIRA: begin
                pin_out = mir_a;
                pin_oe  = 1'b1;
            end
            LPF_FN_MIRB: begin
                pin_out = mir_b;
                pin_oe  = 1'b1;
            end
            default: begin
                pin_out = 1'b0;
                pin_oe  = 1'b0;
            end
        endcase
    end
endmodule

// >>> lpf_apb_slave.sv
// apb slave front end with one wait state per transfer
// assumes an apb master that holds its request until pready is seen
`timescale 1ns/1ps
module lpf_apb_slave
    import lpf_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    lpf_reg_if.slave         bus
);
    typedef struct packed {
        lpf_apb_state_t st;
        logic           rdy;
        logic [31:0]    rd;
        logic           err;
    } lpf_apb_t;

    lpf_apb_t s;
    lpf_apb_t next_s;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // the write lands on the very edge at which the master sees pready
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    assign bus.wr    = (s.st == LPF_ACK) & psel & penable & pwrite & ~s.err;
    assign pready    = s.rdy;
    assign prdata    = s.rd;
    assign pslverr   = s.err;

    // read data is captured a cycle early so it comes from a flop
    always_comb begin
        next_s = s;
        case (s.st)
            LPF_IDLE: begin
                if (psel & penable) begin
                    next_s.st  = LPF_ACK;
                    next_s.rdy = 1'b1;
                    next_s.err = ~bus.hit;
                    next_s.rd  = (bus.hit & ~pwrite) ? bus.rdata : 32'h0;
                end
            end
            LPF_ACK: begin
                next_s.st  = LPF_IDLE;
                next_s.rdy = 1'b0;
                next_s.err = 1'b0;
                next_s.rd  = 32'h0;
            end
            default: begin
                next_s.st = LPF_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s    <= '0;
            s.st <= LPF_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule

// >>> lpf_pin_function_select.sv
// led and shared general-purpose pin function select, top level
// assumes apb software access, strap-like eeprom inputs valid at reset release,
// and status, mii and pin inputs synchronous to ref_clk
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module lpf_pin_function_select
    import lpf_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        eeprom_present,
    input  wire logic        eeprom_led_role_select,
    input  wire logic        usb_reset,
    input  wire logic        lite_reset,
    input  wire logic        link_speed_100,
    input  wire logic        link_up,
    input  wire logic        activity,
    input  wire logic        mii_rxd0,
    input  wire logic        mii_rxd1,
    input  wire logic        mii_rxd3,
    input  wire logic        internal_phy_reset_low,
    input  wire logic        general_purpose_pin_9_in,
    output logic             general_purpose_pin_9_out,
    output logic             general_purpose_pin_9_oe,
    input  wire logic        general_purpose_pin_10_in,
    output logic             general_purpose_pin_10_out,
    output logic             general_purpose_pin_10_oe,
    output logic             speed_indicator_out_n,
    output logic             link_activity_indicator_out_n,
    output logic             duplex_indicator_out_n,
    output logic [1:0]       pin_wake_event,
    output logic [1:0]       pin_irq_event
);
    import lpf_pkg::*;

    // index 0 is pin 9, index 1 is pin 10 throughout
    typedef struct packed {
        logic       role;
        logic       image;
        logic       load_pend;
        logic [1:0] p10fn;
        logic [1:0] p9fn;
        logic [1:0] pp;
        logic [1:0] dir;
        logic [1:0] dat;
        logic [1:0] wk_en;
        logic [1:0] wk_pol;
        logic       dpx_en;
        logic       dpx_lit;
        logic [1:0] prev_pin;
        logic       spd_n;
        logic       lnk_n;
        logic       dpx_n;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic [1:0] wake;
        logic [1:0] irq;
    } lpf_top_t;

    lpf_top_t   s;
    lpf_top_t   next_s;
    lpf_reg_if  regs ();
    logic [1:0] pin_in;
    logic [1:0] mux_out;
    logic [1:0] mux_oe;
    logic [1:0] gp_input;
    logic       spd_lit;
    logic       lnk_lit;
    logic       dpx_lit;

    assign pin_in = {general_purpose_pin_10_in, general_purpose_pin_9_in};

    // ------------------------------------------------------------
    // bus front end and pin muxes
    // ------------------------------------------------------------
    lpf_apb_slave u_apb (
        .ref_clk (ref_clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .bus     (regs.slave)
    );

    // pin 9 code 01 carries the link led whose meaning follows the role
    lpf_pin_mux u_mux9 (
        .fn        (s.p9fn),
        .dir       (s.dir[0]),
        .push_pull (s.pp[0]),
        .dat       (s.dat[0]),
        .led_n     (lpf_led_n(lnk_lit)),
        .mir_a     (mii_rxd1),
        .mir_b     (internal_phy_reset_low),
        .pin_out   (mux_out[0]),
        .pin_oe    (mux_oe[0]),
        .gp_input  (gp_input[0])
    );

    lpf_pin_mux u_mux10 (
        .fn        (s.p10fn),
        .dir       (s.dir[1]),
        .push_pull (s.pp[1]),
        .dat       (s.dat[1]),
        .led_n     (lpf_led_n(spd_lit)),
        .mir_a     (mii_rxd0),
        .mir_b     (mii_rxd3),
        .pin_out   (mux_out[1]),
        .pin_oe    (mux_oe[1]),
        .gp_input  (gp_input[1])
    );

    // ------------------------------------------------------------
    // led roles
    // ------------------------------------------------------------
    // activity blinks the combined led off, a common link/activity habit
    always_comb begin
        spd_lit = link_speed_100;
        if (s.role) begin
            lnk_lit = link_up;
            dpx_lit = activity;
        end else begin
            lnk_lit = link_up & ~activity;
            dpx_lit = s.dpx_en ? s.dpx_lit : activity;
        end
    end

    // ------------------------------------------------------------
    // register read side
    // ------------------------------------------------------------
    // data bits read the pin itself while it is an input
    always_comb begin
        regs.rdata = 32'h0;
        regs.hit   = 1'b1;
        case (regs.addr)
            LPF_CFG_OFF: begin
                regs.rdata[LPF_ROLE_BIT]             = s.role;
                regs.rdata[LPF_P10_LSB +: 2]         = s.p10fn;
                regs.rdata[LPF_P9_LSB +: 2]          = s.p9fn;
                regs.rdata[LPF_BUF_LSB +: 2]         = s.pp;
                regs.rdata[LPF_DIR_LSB +: 2]         = s.dir;
                regs.rdata[LPF_DAT_LSB +: 2]         = (s.dir & s.dat) | (~s.dir & pin_in);
            end
            LPF_WAKE_OFF: begin
                regs.rdata[LPF_WK_EN_LSB +: 2]       = s.wk_en;
                regs.rdata[LPF_WK_POL_LSB +: 2]      = s.wk_pol;
            end
            LPF_LEDC_OFF: begin
                regs.rdata[LPF_DPX_EN_BIT]           = s.dpx_en;
                regs.rdata[LPF_DPX_LIT_BIT]          = s.dpx_lit;
            end
            default: begin
                regs.hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a usb or lite reset beats a software write of the role bit
    always_comb begin
        next_s = s;
        if (regs.wr) begin
            case (regs.addr)
                LPF_CFG_OFF: begin
                    next_s.role  = regs.wdata[LPF_ROLE_BIT];
                    next_s.p10fn = regs.wdata[LPF_P10_LSB +: 2];
                    next_s.p9fn  = regs.wdata[LPF_P9_LSB +: 2];
                    next_s.pp    = regs.wdata[LPF_BUF_LSB +: 2];
                    next_s.dir   = regs.wdata[LPF_DIR_LSB +: 2];
                    next_s.dat   = regs.wdata[LPF_DAT_LSB +: 2];
                end
                LPF_WAKE_OFF: begin
                    next_s.wk_en  = regs.wdata[LPF_WK_EN_LSB +: 2];
                    next_s.wk_pol = regs.wdata[LPF_WK_POL_LSB +: 2];
                end
                LPF_LEDC_OFF: begin
                    next_s.dpx_en  = regs.wdata[LPF_DPX_EN_BIT];
                    next_s.dpx_lit = regs.wdata[LPF_DPX_LIT_BIT];
                end
                default: begin
                    next_s.role = s.role;
                end
            endcase
        end
        // eeprom image is caught one cycle after reset release
        if (s.load_pend) begin
            next_s.load_pend = 1'b0;
            next_s.image     = eeprom_present & eeprom_led_role_select;
            next_s.role      = eeprom_present & eeprom_led_role_select;
        end else if (usb_reset | lite_reset) begin
            next_s.role = s.image;
        end
        // registered outputs
        next_s.spd_n    = lpf_led_n(spd_lit);
        next_s.lnk_n    = lpf_led_n(lnk_lit);
        next_s.dpx_n    = lpf_led_n(dpx_lit);
        next_s.pin_out  = mux_out;
        next_s.pin_oe   = mux_oe;
        next_s.prev_pin = pin_in;
        // events only from gpio pins set as inputs
        next_s.irq  = gp_input & (pin_in ^ s.prev_pin);
        next_s.wake = gp_input & s.wk_en & (pin_in ^ s.prev_pin)
                      & ~(pin_in ^ s.wk_pol);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s           <= '0;
            s.role      <= LPF_ROLE_RST;
            s.p10fn     <= LPF_FN_RST;
            s.p9fn      <= LPF_FN_RST;
            s.load_pend <= 1'b1;
            s.spd_n     <= LPF_LED_OFF;
            s.lnk_n     <= LPF_LED_OFF;
            s.dpx_n     <= LPF_LED_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign speed_indicator_out_n         = s.spd_n;
    assign link_activity_indicator_out_n = s.lnk_n;
    assign duplex_indicator_out_n        = s.dpx_n;
    assign general_purpose_pin_9_out     = s.pin_out[0];
    assign general_purpose_pin_9_oe      = s.pin_oe[0];
    assign general_purpose_pin_10_out    = s.pin_out[1];
    assign general_purpose_pin_10_oe     = s.pin_oe[1];
    assign pin_wake_event                = s.wake;
    assign pin_irq_event                 = s.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_cfg_role_write: assert property (@(posedge ref_clk) disable iff (rst)
        (regs.wr && regs.addr == LPF_CFG_OFF && !usb_reset && !lite_reset && !s.load_pend)
        |=> (s.role == $past(regs.wdata[LPF_ROLE_BIT])))
        else $error("role bit did not take the written value");
    chk_irq_input_only: assert property (@(posedge ref_clk) disable iff (rst)
        (s.irq[0] || s.wake[0]) |-> ($past(s.p9fn) == LPF_FN_GPIO && !$past(s.dir[0])))
        else $error("pin 9 event while not a gpio input");
    chk_wake_needs_en: assert property (@(posedge ref_clk) disable iff (rst)
        s.wake[1] |-> ($past(s.wk_en[1]) && !$past(s.dir[1])))
        else $error("pin 10 wake without enable");
    chk_role1_link_led: assert property (@(posedge ref_clk) disable iff (rst)
        s.role |=> (link_activity_indicator_out_n == !$past(link_up)))
        else $error("link led wrong in role 1");
    chk_dpx_default_act: assert property (@(posedge ref_clk) disable iff (rst)
        (!s.role && !s.dpx_en) |=> (duplex_indicator_out_n == !$past(activity)))
        else $error("duplex led does not show activity by default");
    chk_pin10_fn_reset: assert property (@(posedge ref_clk)
        $fell(rst) |-> (s.p10fn == LPF_FN_GPIO))
        else $error("pin 10 function not gpio after reset");
    chk_pin10_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        (s.p10fn == LPF_FN_MIRA) |=> (general_purpose_pin_10_out == $past(mii_rxd0) && general_purpose_pin_10_oe))
        else $error("pin 10 does not mirror rxd0");
    chk_pin9_fn_reset: assert property (@(posedge ref_clk)
        $fell(rst) |-> (s.p9fn == LPF_FN_GPIO && s.role == LPF_ROLE_RST))
        else $error("pin 9 function not gpio after reset");
    chk_pin9_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        (s.p9fn == LPF_FN_MIRB) |=> (general_purpose_pin_9_out == $past(internal_phy_reset_low)))
        else $error("pin 9 does not mirror phy reset");
    chk_role_restore: assert property (@(posedge ref_clk) disable iff (rst)
        ((usb_reset || lite_reset) && !s.load_pend) |=> (s.role == $past(s.image)))
        else $error("role not restored to image");
    chk_pin9_led_role: assert property (@(posedge ref_clk) disable iff (rst)
        (s.p9fn == LPF_FN_LED) |=> (general_purpose_pin_9_out == link_activity_indicator_out_n))
        else $error("pin 9 led does not follow the role");
endmodule

// >>> lpf_far_pins.sv
// far side of the shared pins: pull-ups plus one external driver on pin 9
// assumes the device drives out/oe as registered levels
`timescale 1ns/1ps
module lpf_far_pins (
    input  wire logic pin9_out,
    input  wire logic pin9_oe,
    input  wire logic pin10_out,
    input  wire logic pin10_oe,
    input  wire logic ext9_oe,
    input  wire logic ext9,
    output logic      pin9_lvl,
    output logic      pin10_lvl
);
    // a released line floats to its pull-up, so an open drain reads high
    assign pin9_lvl  = pin9_oe ? pin9_out : (ext9_oe ? ext9 : 1'h1);
    assign pin10_lvl = pin10_oe ? pin10_out : 1'h1;
endmodule

// >>> tb_top.sv
// self-checking bench of the led / shared pin function select
// assumes one-wait-state apb answers and one-flop pin latency
`timescale 1ns/1ps
module tb_top;
    import lpf_pkg::*;
    logic        ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic        eeprom_present = 1'h0, eeprom_led_role_select = 1'h0, usb_reset = 1'h0, lite_reset = 1'h0;
    logic        link_speed_100 = 1'h0, link_up = 1'h0, activity = 1'h0, ext9_oe = 1'h0, ext9 = 1'h0;
    logic        mii_rxd0 = 1'h0, mii_rxd1 = 1'h0, mii_rxd3 = 1'h0, internal_phy_reset_low = 1'h1;
    wire logic [31:0] prdata;
    wire logic [1:0]  pin_wake_event, pin_irq_event;
    wire logic        pready, pslverr, speed_indicator_out_n, link_activity_indicator_out_n;
    wire logic        duplex_indicator_out_n, general_purpose_pin_9_in, general_purpose_pin_10_in;
    wire logic        general_purpose_pin_9_out, general_purpose_pin_9_oe;
    wire logic        general_purpose_pin_10_out, general_purpose_pin_10_oe;
    wire logic [4:0]  obs = {general_purpose_pin_9_in, general_purpose_pin_10_in, speed_indicator_out_n,
                             link_activity_indicator_out_n, duplex_indicator_out_n};
    int          mismatches = 0, total_checks = 0, irq_n = 0, wk_n = 0, b_irq, b_wk;
    // rows: config, {speed100, link, activity}, {rxd0, rxd1, rxd3, phy reset}, {pin9, pin10, leds}
    logic [43:0] rows [5] = '{{32'h0220_0000, 3'h6, 4'hA, 5'h09}, {32'h0330_0000, 3'h3, 4'h5, 5'h16},
                              {32'h8110_0000, 3'h7, 4'hF, 5'h00}, {32'h0110_0000, 3'h3, 4'h0, 5'h1E},
                              {32'h0220_0000, 3'h0, 4'h5, 5'h17}};

    lpf_pin_function_select i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .eeprom_present, .eeprom_led_role_select, .usb_reset, .lite_reset, .link_speed_100,
        .link_up, .activity, .mii_rxd0, .mii_rxd1, .mii_rxd3, .internal_phy_reset_low,
        .general_purpose_pin_9_in, .general_purpose_pin_9_out, .general_purpose_pin_9_oe,
        .general_purpose_pin_10_in, .general_purpose_pin_10_out, .general_purpose_pin_10_oe,
        .speed_indicator_out_n, .link_activity_indicator_out_n, .duplex_indicator_out_n,
        .pin_wake_event, .pin_irq_event);
    lpf_far_pins i_far (.pin9_out(general_purpose_pin_9_out), .pin9_oe(general_purpose_pin_9_oe),
        .pin10_out(general_purpose_pin_10_out), .pin10_oe(general_purpose_pin_10_oe), .ext9_oe(ext9_oe),
        .ext9(ext9), .pin9_lvl(general_purpose_pin_9_in), .pin10_lvl(general_purpose_pin_10_in));

    // ------------------------------------------------------------
    // clock, event counters and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // pulses last one cycle, so count them rather than poll
    always @(posedge ref_clk) begin
        if (!rst) begin
            irq_n <= irq_n + pin_irq_event[0] + pin_irq_event[1];
            wk_n  <= wk_n + pin_wake_event[0] + pin_wake_event[1];
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high at an edge
    // only the watchdog ends a wait that never sees pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        settle;
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        print_verdict;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset;
        chk(obs[2:0], 32'h7);
        apb(1'h0, LPF_CFG_OFF, 32'h0);
        // both pins are floating inputs, so the data bits read the pull-ups
        chk(rd, 32'h0000_0006);
        apb(1'h0, 12'h030, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            @(posedge ref_clk);
            {link_speed_100, link_up, activity} <= rows[i][11:9];
            {mii_rxd0, mii_rxd1, mii_rxd3, internal_phy_reset_low} <= rows[i][8:5];
            apb(1'h1, LPF_CFG_OFF, rows[i][43:12]);
            apb(1'h0, LPF_CFG_OFF, 32'h0);
            chk(rd, rows[i][43:12] | {29'h0, rows[i][3], rows[i][4], 1'h0});
            settle;
            chk(obs, rows[i][4:0]);
        end
        // input pin with wake enabled, then disabled, then as an output
        apb(1'h1, LPF_CFG_OFF, 32'h0);
        apb(1'h1, LPF_WAKE_OFF, 32'h0000_0101);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            {ext9_oe, ext9} <= 2'h2;
            settle;
            b_irq = irq_n;
            b_wk = wk_n;
            @(posedge ref_clk);
            ext9 <= 1'h1;
            settle;
            chk(irq_n - b_irq, 32'h1);
            chk(wk_n - b_wk, k ? 32'h0 : 32'h1);
            apb(1'h1, LPF_WAKE_OFF, 32'h0000_0100);
        end
        @(posedge ref_clk);
        ext9_oe <= 1'h0;
        apb(1'h1, LPF_WAKE_OFF, 32'h0000_0101);
        apb(1'h1, LPF_CFG_OFF, 32'h0000_0220);
        settle;
        b_irq = irq_n;
        b_wk = wk_n;
        apb(1'h1, LPF_CFG_OFF, 32'h0000_0222);
        settle;
        chk(general_purpose_pin_9_in, 32'h1);
        chk(irq_n - b_irq + wk_n - b_wk, 32'h0);
        // pin 10 released from a driven low rises to its pull-up
        apb(1'h1, LPF_WAKE_OFF, 32'h0000_0202);
        apb(1'h1, LPF_CFG_OFF, 32'h0000_0440);
        settle;
        b_irq = irq_n;
        b_wk = wk_n;
        apb(1'h1, LPF_CFG_OFF, 32'h0);
        settle;
        chk(irq_n - b_irq, 32'h1);
        chk(wk_n - b_wk, 32'h1);
        // duplex led shows activity until software takes it over
        apb(1'h1, LPF_CFG_OFF, 32'h0);
        @(posedge ref_clk);
        {link_speed_100, link_up, activity} <= 3'h1;
        for (int k = 0; k < 3; k++) begin
            apb(1'h1, LPF_LEDC_OFF, (k == 2) ? 32'h3 : k);
            settle;
            chk(duplex_indicator_out_n, (k == 1) ? 32'h1 : 32'h0);
        end
        // role select image from eeprom, restored by usb then lite reset
        @(posedge ref_clk);
        {eeprom_present, eeprom_led_role_select} <= 2'h3;
        do_reset;
        apb(1'h0, LPF_CFG_OFF, 32'h0);
        chk(rd[31], 32'h1);
        for (int k = 0; k < 2; k++) begin
            apb(1'h1, LPF_CFG_OFF, 32'h0);
            @(posedge ref_clk);
            {usb_reset, lite_reset} <= k ? 2'h1 : 2'h2;
            @(posedge ref_clk);
            {usb_reset, lite_reset} <= 2'h0;
            apb(1'h0, LPF_CFG_OFF, 32'h0);
            chk(rd[31], 32'h1);
        end
        print_verdict;
    end
endmodule
